// ---- verilog/sar_adc_sequencer.sv ----
// Sequencer for a 10-bit SAR converter with a 32-way input multiplexer
`include "sar_adc_consts.svh"

module sar_adc_sequencer
   import sar_adc_pkg::*;
#(
   parameter int DATA_W = 10,
   parameter int N_RES = 12,
   parameter logic [11:0] SLOT_CYCLES = 12'(`SEQ_SLOT_CYCLES)
)(
   input wire logic ref_clk_i,                  // Core clock, 50 MHz
   input wire logic rstn_i,                     // Asynchronous reset, active low
   input wire logic enable_i,                   // Converter enable
   input mode_e mode_i,                         // Operating mode
   input wire logic [4:0] channel_i,            // Single mode channel
   input wire logic continuous_i,               // Repeat in single mode
   input wire logic start_i,                    // Start pulse
   input wire logic [7:0] en_delay_i,           // Enable delay in cycles
   input wire logic [7:0] sample_cycles_i,      // Sample window in cycles
   input wire logic [DATA_W-1:0] conv_data_i,   // Result from analog core
   input wire logic [3:0] rd_ch_i,              // Result register index
   output logic [DATA_W-1:0] rd_data_o,         // Result register contents
   output logic [4:0] mux_sel_o,                // Multiplexer select
   output logic [4:0] div_ratio_o,              // Input divider ratio
   output logic sample_o,                       // Sample switch closed
   output logic convert_o,                      // Conversion phase
   output logic irq_o,                          // Interrupt to core
   output logic [DATA_W-1:0] data_o,            // Latest single result
   output logic [4:0] data_ch_o,                // Channel of data_o
   output logic busy_o,                         // Sequence in progress
   output logic sweep_done_o                    // One time sweep halted
);

   typedef struct packed {
      state_e st;
      logic warm;
      logic once_end;
      logic [4:0] chan;
      logic [11:0] cnt;
      logic [11:0] slot;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
      logic [DATA_W-1:0] data;
      logic [4:0] data_ch;
      logic [N_RES-1:0][DATA_W-1:0] res;
      logic [DATA_W-1:0] rd;
   } state_s;

   localparam state_s Q_RST = '{st: ST_IDLE, default: '0};
   localparam logic [31:0] RES_MASK = `SEQ_RESERVED_MASK;
   localparam logic [11:0] AUTO_MASK = `SEQ_AUTO_MASK;

   state_s q;
   state_s d;
   logic [5:0] nxt;
   logic [5:0] first;

   function automatic logic is_reserved(input logic [4:0] ch);
      return RES_MASK[ch];
   endfunction

   // Next auto channel above ch; top bit marks wrap to the first one
   function automatic logic [5:0] next_auto(input logic [4:0] ch);
      logic [5:0] r;
      r = {1'b1, 5'h00};
      for (int i = `SEQ_AUTO_LAST; i >= 0; i--)
      begin
         if (AUTO_MASK[i])
         begin
            r = {1'b1, 5'(i)};
         end
      end
      for (int i = `SEQ_AUTO_LAST; i >= 0; i--)
      begin
         if (AUTO_MASK[i] && (5'(i) > ch))
         begin
            r = {1'b0, 5'(i)};
         end
      end
      return r;
   endfunction

   // Zero means the input passes undivided
   function automatic logic [4:0] div_ratio(input logic [4:0] ch);
      logic [4:0] r;
      r = `SEQ_DIV_NONE;
      case (ch)
         5'h01, 5'h02: r = 5'h19;
         5'h0B: r = 5'h01;
         5'h0F, 5'h10: r = 5'h03;
         5'h12, 5'h13: r = 5'h02;
         default:
         begin
            if (ch >= 5'h14)
            begin
               r = 5'h03;
            end
         end
      endcase
      return r;
   endfunction

   // Phase ends once the count reaches the limit; a zero limit acts as one
   function automatic logic reached(input logic [11:0] c, input logic [11:0] lim);
      return (c + 12'h001) >= lim;
   endfunction

   assign nxt = next_auto(q.chan);
   assign first = next_auto(`SEQ_FIRST_SEARCH);

   always_comb
   begin
      d = q;
      d.sync1 = conv_data_i;
      d.sync2 = q.sync1;
      d.rd = (rd_ch_i < 4'(N_RES)) ? q.res[rd_ch_i] : `SEQ_RESULT_RST;
      d.slot = q.slot + 12'h001;
      d.cnt = q.cnt + 12'h001;
      if (!enable_i)
      begin
         // Abort any phase; the interrupt state is left without a pulse
         d.st = ST_IDLE;
         d.warm = 1'b0;
         d.once_end = 1'b0;
         d.cnt = 12'h000;
      end
      else
      begin
         unique case (q.st)
            ST_IDLE:
            begin
               d.cnt = 12'h000;
               d.slot = 12'h000;
               if (!q.warm)
               begin
                  d.st = ST_ENWAIT;
               end
               else if (mode_i == MODE_SINGLE)
               begin
                  if (start_i && !is_reserved(channel_i))
                  begin
                     d.chan = channel_i;
                     d.st = ST_SAMPLE;
                  end
               end
               else if (mode_i == MODE_ROUND || mode_i == MODE_ONCE)
               begin
                  d.chan = first[4:0];
                  d.st = ST_SAMPLE;
               end
            end
            ST_ENWAIT:
            begin
               if (reached(q.cnt, {4'h0, en_delay_i}))
               begin
                  d.warm = 1'b1;
                  d.st = ST_IDLE;
               end
            end
            ST_SAMPLE:
            begin
               if (reached(q.cnt, {4'h0, sample_cycles_i}))
               begin
                  d.cnt = 12'h000;
                  d.st = ST_CONVERT;
               end
            end
            ST_CONVERT:
            begin
               if (reached(q.cnt, `SEQ_CONV_CYCLES))
               begin
                  d.cnt = 12'h000;
                  if (mode_i == MODE_SINGLE)
                  begin
                     d.data = q.sync2;
                     d.data_ch = q.chan;
                     d.st = ST_IRQ;
                  end
                  else
                  begin
                     // Newest value replaces the old one
                     d.res[q.chan] = q.sync2;
                     if (nxt[5] && mode_i == MODE_ONCE)
                     begin
                        d.once_end = 1'b1;
                        d.st = ST_IRQ;
                     end
                     else
                     begin
                        d.st = ST_GAP;
                     end
                  end
               end
            end
            ST_GAP:
            begin
               // Each auto channel occupies a fixed slot
               if (q.slot >= SLOT_CYCLES - 12'h001)
               begin
                  d.cnt = 12'h000;
                  d.slot = 12'h000;
                  if (mode_i == MODE_ROUND || mode_i == MODE_ONCE)
                  begin
                     d.chan = nxt[4:0];
                     d.st = ST_SAMPLE;
                  end
                  else
                  begin
                     d.st = ST_IDLE;
                  end
               end
            end
            ST_IRQ:
            begin
               if (reached(q.cnt, `SEQ_IRQ_CYCLES))
               begin
                  d.cnt = 12'h000;
                  d.slot = 12'h000;
                  if (q.once_end)
                  begin
                     d.once_end = 1'b0;
                     d.st = ST_DONE;
                  end
                  else if (mode_i == MODE_SINGLE && continuous_i)
                  begin
                     d.st = ST_SAMPLE;
                  end
                  else
                  begin
                     d.st = ST_IDLE;
                  end
               end
            end
            ST_DONE:
            begin
               // Halted until a new start or a change of mode
               d.cnt = 12'h000;
               if (start_i || mode_i != MODE_ONCE)
               begin
                  d.st = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         q <= Q_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign rd_data_o = q.rd;
   assign mux_sel_o = q.chan;
   assign div_ratio_o = div_ratio(q.chan);
   assign sample_o = (q.st == ST_SAMPLE);
   assign convert_o = (q.st == ST_CONVERT);
   assign irq_o = (q.st == ST_IRQ);
   assign data_o = q.data;
   assign data_ch_o = q.data_ch;
   assign busy_o = (q.st != ST_IDLE) && (q.st != ST_DONE);
   assign sweep_done_o = (q.st == ST_DONE);

endmodule

// ---- verilog/sar_adc_consts.svh ----
// Constants for the SAR converter sequencer
// Function
// - Produce 10-bit results readable by firmware
// - Three modes: single, round robin, one time
// - Single mode converts chosen channel, then interrupts
// - Wait programmable delay after enable rises
// - Programmable sample window, then 12-cycle conversion
// - Publish data, interrupt for two cycles
// - Continuous single mode restarts after interrupt pulse
// - Auto sweep channels 0..3 into result registers
// - Results readable any time without stalling
// - Round robin overwrites results, keeps no history
// - Channel slot about 63.33 us, sweep ~253 us
// - One time sweep stops after final channel
// - One time sweep end raises interrupt
// - Only channels 0..3 auto-sequenced
// - Select 0..31; listed channels reserved
// - Voltage inputs divided to 1.2 V scale
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

`define SEQ_CLK_PERIOD_NS 20
`define SEQ_CONV_CYCLES 12'h00C
`define SEQ_IRQ_CYCLES 12'h002
`define SEQ_SLOT_TIME_NS 63330
`define SEQ_SLOT_CYCLES (`SEQ_SLOT_TIME_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_SWEEP_TIME_NS 696000
`define SEQ_AUTO_LAST 11
`define SEQ_AUTO_MASK 12'h00F
`define SEQ_RESERVED_MASK 32'h0002_77F0
`define SEQ_FIRST_SEARCH 5'h1F
`define SEQ_RESULT_RST 10'h000
`define SEQ_DIV_NONE 5'h00

`endif

// ---- verilog/sar_adc_pkg.sv ----
// Types shared by the SAR converter sequencer
package sar_adc_pkg;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_ROUND = 2'h1,
      MODE_ONCE = 2'h2
   } mode_e;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ENWAIT = 7'h02,
      ST_SAMPLE = 7'h04,
      ST_CONVERT = 7'h08,
      ST_IRQ = 7'h10,
      ST_GAP = 7'h20,
      ST_DONE = 7'h40
   } state_e;

endpackage

// ---- tb/sar_analog_model.sv ----
// Behavioural analog converter core facing the sequencer
module sar_analog_model (
   input wire logic clk_i,           // Core clock
   input wire logic [4:0] mux_sel_i, // Selected input
   input wire logic sample_i,        // Sample window
   input wire logic convert_i,       // Conversion phase
   output logic [9:0] conv_data_o    // Converted code
);
   timeunit 1ns;
   timeprecision 100ps;
   initial conv_data_o = 10'h155;
   // Outside a frame the code toggles every cycle so a stale value never matches
   always @(posedge clk_i)
      if (sample_i || convert_i)
         conv_data_o <= {mux_sel_i, ~mux_sel_i};
      else
         conv_data_o <= ~conv_data_o;
endmodule

// ---- tb/sar_adc_sequencer_assertions.sv ----
// Concurrent checks on the converter sequencer ports
module sar_seq_checker
   import sar_adc_pkg::*;
(
   input wire logic ref_clk_i,       // Core clock
   input wire logic rstn_i,          // Reset, active low
   input wire logic enable_i,        // Converter enable
   input mode_e mode_i,              // Operating mode
   input wire logic continuous_i,    // Repeat in single mode
   input wire logic [4:0] mux_sel_o, // Multiplexer select
   input wire logic sample_o,        // Sample window
   input wire logic convert_o,       // Conversion phase
   input wire logic irq_o,           // Interrupt
   input wire logic busy_o,          // Sequence running
   input wire logic sweep_done_o     // One time sweep halted
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_irq_two_cycles: assert property (disable iff (!rstn_i || !enable_i)
      $rose(irq_o) |=> irq_o ##1 !irq_o) else $error("interrupt pulse not two cycles");
   a_conv_twelve: assert property (disable iff (!rstn_i || !enable_i)
      $rose(convert_o) |-> ##11 convert_o ##1 !convert_o) else $error("conversion length wrong");
   a_sample_then_conv: assert property ($fell(sample_o) && $past(enable_i) |-> convert_o)
      else $error("conversion did not follow sample");
   a_conv_then_irq: assert property (
      $fell(convert_o) && $past(enable_i) && mode_i == MODE_SINGLE |-> irq_o)
      else $error("no interrupt after conversion");
   a_disable_idles: assert property (
      !enable_i |=> !busy_o && !irq_o && !sample_o && !convert_o)
      else $error("disable did not abort");
   a_cont_restart: assert property (
      $fell(irq_o) && enable_i && continuous_i && mode_i == MODE_SINGLE |-> ##[0:1] sample_o)
      else $error("continuous conversion did not restart");
   a_auto_channels: assert property (sample_o && mode_i != MODE_SINGLE |-> mux_sel_o < 5'h04)
      else $error("auto sweep left channels 0 to 3");
   a_once_halted: assert property (
      $rose(sweep_done_o) |-> $past(irq_o) && $past(mux_sel_o) == 5'h03)
      else $error("halt not after final channel interrupt");
   c_irq: cover property ($rose(irq_o));
   c_sweep_done: cover property ($rose(sweep_done_o));
   c_round: cover property (convert_o && mode_i == MODE_ROUND);
endmodule
bind sar_adc_sequencer sar_seq_checker chk (.*);

// ---- tb/sar_adc_sequencer_bench.sv ----
// Self-checking bench for the converter sequencer
module sar_adc_sequencer_bench
   import sar_adc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic enable_i = 1'b0;
   mode_e mode_i = MODE_SINGLE;
   logic [4:0] channel_i = 5'h00;
   logic continuous_i = 1'b0;
   logic start_i = 1'b0;
   logic [7:0] en_delay_i = 8'h03;
   logic [7:0] sample_cycles_i = 8'h04;
   logic [9:0] conv_data_i;
   logic [3:0] rd_ch_i = 4'h0;
   logic [9:0] rd_data_o;
   logic [9:0] data_o;
   logic [4:0] mux_sel_o;
   logic [4:0] div_ratio_o;
   logic [4:0] data_ch_o;
   logic sample_o;
   logic convert_o;
   logic irq_o;
   logic busy_o;
   logic sweep_done_o;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   // Short slot keeps the auto sweeps well inside the run limit
   localparam logic [11:0] SLOT = 12'h028;
   sar_adc_sequencer #(.SLOT_CYCLES(SLOT)) dut (.*);
   sar_analog_model model (.clk_i(ref_clk_i), .mux_sel_i(mux_sel_o), .sample_i(sample_o),
      .convert_i(convert_o), .conv_data_o(conv_data_i));
   initial
   begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   task automatic finish_test();
      if (failures == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         finish_test();
      end
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic check(input string nm, input logic [9:0] e, input logic [9:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic pulse_start(input logic [4:0] ch);
      channel_i = ch;
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
   endtask
   task automatic warm_up(input mode_e m);
      int n;
      n = 0;
      enable_i = 1'b0;
      tick();
      mode_i = m;
      enable_i = 1'b1;
      repeat (6)
      begin
         tick();
         n += int'(busy_o);
      end
      // Auto modes start sampling at once, so only single mode shows the bare delay
      if (m == MODE_SINGLE)
      begin
         check("enable delay", 10'(en_delay_i), 10'(n));
      end
   endtask
   task automatic single_conv(input logic [4:0] ch, input logic [4:0] div);
      int ns;
      ns = 0;
      pulse_start(ch);
      check("div_ratio_o", 10'(div), 10'(div_ratio_o));
      for (int k = 0; k < 200 && irq_o !== 1'b1; k++)
      begin
         ns += int'(sample_o);
         tick();
      end
      check("sample window", 10'(sample_cycles_i), 10'(ns));
      check("data_o", {ch, ~ch}, data_o);
      check("data_ch_o", 10'(ch), 10'(data_ch_o));
      tick();
      check("irq_o second", 10'h001, 10'(irq_o));
      tick();
      check("irq_o end", 10'h000, 10'(irq_o));
   endtask
   task automatic t_single();
      warm_up(MODE_SINGLE);
      single_conv(5'h00, 5'h00);
      single_conv(5'h01, 5'h19);
      single_conv(5'h0B, 5'h01);
      single_conv(5'h12, 5'h02);
      single_conv(5'h1F, 5'h03);
      pulse_start(5'h05);
      tick(2);
      check("busy_o reserved", 10'h000, 10'(busy_o));
   endtask
   task automatic t_cont();
      logic seen;
      seen = 1'b0;
      continuous_i = 1'b1;
      pulse_start(5'h10);
      for (int k = 0; k < 200 && irq_o !== 1'b1; k++) tick();
      tick(4);
      check("sample_o restart", 10'h001, 10'(sample_o));
      check("mux_sel_o", 10'h010, 10'(mux_sel_o));
      tick(6);
      enable_i = 1'b0;
      continuous_i = 1'b0;
      repeat (20)
      begin
         tick();
         seen |= irq_o;
      end
      check("irq_o abort", 10'h000, 10'(seen));
      check("busy_o abort", 10'h000, 10'(busy_o));
   endtask
   task automatic t_round();
      int n;
      warm_up(MODE_ROUND);
      tick(400);
      for (int c = 0; c < 4; c++)
      begin
         rd_ch_i = 4'(c);
         tick();
         check("rd_data_o", {5'(c), ~5'(c)}, rd_data_o);
      end
      rd_ch_i = 4'hC;
      tick();
      check("rd_data_o unused", 10'h000, rd_data_o);
      check("busy_o running", 10'h001, 10'(busy_o));
      // Align to a sample start, then time one whole channel slot
      for (int k = 0; k < 100 && sample_o !== 1'b0; k++) tick();
      for (int k = 0; k < 100 && sample_o !== 1'b1; k++) tick();
      n = 0;
      for (int k = 0; k < 100 && sample_o !== 1'b0; k++)
      begin
         tick();
         n++;
      end
      for (int k = 0; k < 100 && sample_o !== 1'b1; k++)
      begin
         tick();
         n++;
      end
      check("slot cycles", 10'(SLOT), 10'(n));
   endtask
   task automatic t_once();
      logic seen;
      seen = 1'b0;
      warm_up(MODE_ONCE);
      for (int k = 0; k < 400 && sweep_done_o !== 1'b1; k++)
      begin
         tick();
         seen |= irq_o;
      end
      check("sweep_done_o", 10'h001, 10'(sweep_done_o));
      check("irq_o sweep end", 10'h001, 10'(seen));
      tick(80);
      check("sample_o halted", 10'h000, 10'(sample_o));
      pulse_start(5'h00);
      tick();
      check("sample_o resweep", 10'h001, 10'(sample_o));
      check("mux_sel_o first", 10'h000, 10'(mux_sel_o));
   endtask
   initial
   begin
      tick(2);
      rstn_i = 1'b1;
      t_single();
      t_cont();
      t_round();
      t_once();
      finish_test();
   end
endmodule
